// file: design/bsc_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and types for the boundary-scan test access port.
// Assumes: Instruction register of four bits and a scan chain of eight cells.
// Notes:   The identification fields are arbitrary values of our own.
////////////////////////////////////////////////////////////////////////////////
package bsc_pkg;

	localparam int TEST_PINS = 5;
	localparam int IR_LEN    = 4;
	localparam int ID_LEN    = 32;
	localparam int IN_CELLS  = 4;
	localparam int OUT_CELLS = 4;
	localparam int BSR_LEN   = IN_CELLS + OUT_CELLS;
	localparam int PIN_BITS  = 4;
	localparam int SYNC_LEN  = PIN_BITS + IN_CELLS;

	// Positions of the test pins in the synchroniser vector.
	localparam int POS_TCK  = 3;
	localparam int POS_TMS  = 2;
	localparam int POS_TDI  = 1;
	localparam int POS_TRST = 0;

	// The three identity fields below are arbitrary values.
	localparam logic [3:0]  ID_VERSION = 4'h1;
	localparam logic [15:0] ID_PART    = 16'h5A3C;
	localparam logic [10:0] ID_MAKER   = 11'h02A;
	localparam logic [ID_LEN-1:0] ID_CODE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

	localparam logic [IR_LEN-1:0]   IR_CAPTURE  = 4'h1;
	localparam logic [SYNC_LEN-1:0] SYNC_RESET  = 8'h00;
	localparam logic [OUT_CELLS-1:0] CELL_RESET = 4'h0;

	typedef enum logic [IR_LEN-1:0] {
		INS_EXTEST = 4'h0,
		INS_SAMPLE = 4'h1,
		INS_IDCODE = 4'h2,
		INS_CLAMP  = 4'h3,
		INS_BYPASS = 4'hF
	} bsc_instr_e;

	typedef enum logic [15:0] {
		ST_RESET  = 16'h0001,
		ST_IDLE   = 16'h0002,
		ST_SEL_DR = 16'h0004,
		ST_CAP_DR = 16'h0008,
		ST_SH_DR  = 16'h0010,
		ST_EX1_DR = 16'h0020,
		ST_PAU_DR = 16'h0040,
		ST_EX2_DR = 16'h0080,
		ST_UPD_DR = 16'h0100,
		ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400,
		ST_SH_IR  = 16'h0800,
		ST_EX1_IR = 16'h1000,
		ST_PAU_IR = 16'h2000,
		ST_EX2_IR = 16'h4000,
		ST_UPD_IR = 16'h8000
	} bsc_state_e;

	typedef enum logic [1:0] {
		PATH_BYPASS = 2'h0,
		PATH_ID     = 2'h1,
		PATH_CHAIN  = 2'h2
	} bsc_path_e;

	typedef struct packed {
		logic testClock;
		logic testModeSelect;
		logic testDataIn;
		logic testResetN;
	} bsc_pins_s;

	// Selects the data register that an instruction puts between the data pins.
	function automatic bsc_path_e bsc_path(input logic [IR_LEN-1:0] instr);
		bsc_path_e path;
		path = PATH_BYPASS;
		if (instr == INS_IDCODE) begin
			path = PATH_ID;
		end else if (instr == INS_EXTEST || instr == INS_SAMPLE) begin
			path = PATH_CHAIN;
		end
		return path;
	endfunction : bsc_path

	function automatic logic bsc_is_shift(input bsc_state_e st);
		return st == ST_SH_DR || st == ST_SH_IR;
	endfunction : bsc_is_shift

endpackage : bsc_pkg

// file: design/bsc_sync.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose: Three-stage synchroniser with agreement filter and edge pulses.
// Assumes: Inputs are slow compared with the clock.
// Notes:   A change is taken once the second and third stages agree.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module bsc_sync
	import bsc_pkg::*;
#(
	parameter int WIDTH = SYNC_LEN
) (
	input  logic             clock,
	input  logic             reset,
	input  logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] second;
	logic [WIDTH-1:0] third;
	logic [WIDTH-1:0] agree;
	logic [WIDTH-1:0] next_level;

	assign agree      = ~(second ^ third);
	assign next_level = (agree & third) | (~agree & level);

	always_ff @(posedge clock) begin
		if (reset) begin
			meta   <= '0;
			second <= '0;
			third  <= '0;
			level  <= '0;
			rise   <= '0;
			fall   <= '0;
		end else begin
			meta   <= asyncIn;
			second <= meta;
			third  <= second;
			level  <= next_level;
			rise   <= next_level & ~level;
			fall   <= ~next_level & level;
		end
	end

endmodule : bsc_sync

// file: design/bsc_tap_fsm.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose: Sixteen-state test access port controller.
// Assumes: step is a one-cycle pulse on each rising test clock edge.
// Notes:   hold forces the test-logic-reset state at once.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module bsc_tap_fsm
	import bsc_pkg::*;
(
	input  logic       clock,
	input  logic       hold,
	input  logic       step,
	input  logic       tms,
	output bsc_state_e state
);

	bsc_state_e advance;
	bsc_state_e next_state;

	always_comb begin
		case (state)
			ST_RESET:  advance = tms ? ST_RESET  : ST_IDLE;
			ST_IDLE:   advance = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: advance = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: advance = tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR:  advance = tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: advance = tms ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: advance = tms ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: advance = tms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: advance = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: advance = tms ? ST_RESET  : ST_CAP_IR;
			ST_CAP_IR: advance = tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR:  advance = tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: advance = tms ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: advance = tms ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: advance = tms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: advance = tms ? ST_SEL_DR : ST_IDLE;
			default:   advance = ST_RESET;
		endcase
	end

	assign next_state = step ? advance : state;

	always_ff @(posedge clock) begin
		if (hold) begin
			state <= ST_RESET;
		end else begin
			state <= next_state;
		end
	end

	sequence seqSelectToCapture;
		state == ST_SEL_DR && step && !tms;
	endsequence

	fsm_capture_a: assert property (@(posedge clock) disable iff (hold)
		seqSelectToCapture |=> state == ST_CAP_DR)
		else $error("Select-DR with TMS low did not reach Capture-DR.");

	fsm_idle_a: assert property (@(posedge clock) disable iff (hold)
		(state == ST_IDLE && step && tms) |=> state == ST_SEL_DR ##1 state == ST_SEL_DR)
		else $error("Run-Test-Idle with TMS high did not move to Select-DR.");

	fsm_still_a: assert property (@(posedge clock) disable iff (hold)
		!step |=> state == $past(state))
		else $error("Controller moved without a rising test clock edge.");

endmodule : bsc_tap_fsm

// file: design/bsc_tap_top.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose: Boundary-scan test access port with bypass, id and scan chain.
// Assumes: Test pins are asynchronous and slow against the 40 MHz clock.
// Notes:   Test clock edges are found by sampling; TDO moves on falling edges.
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Five test pins: mode select, clock, reset, data in, data out.
// - Bypass puts one shift stage between data in and data out.
// - External test lets the scan chain drive and observe the pins.
// - Sample captures pin inputs while pins keep their normal function.
// - Sample also preloads shifted values into the output update latches.
// - Clamp selects bypass while the scan chain keeps driving the pins.
// - Identification instruction selects the id register as serial path.
// - Id register loads the fixed code in capture, then shifts it out.
// - Id register is 32 bits with maker, part and version fields.
// - Bit 31 sits nearest data in, bit 0 nearest data out and leaves first.
// - Test reset low forces test-logic-reset without a test clock edge.
// - Test-logic-reset loads the identification instruction.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module bsc_tap_top
	import bsc_pkg::*;
(
	input  logic                 clock,
	input  logic                 reset,
	input  logic                 testClock,
	input  logic                 testModeSelect,
	input  logic                 testDataIn,
	input  logic                 testResetN,
	output logic                 testDataOut,
	output logic                 testDataOutEn,
	input  logic [IN_CELLS-1:0]  padIn,
	input  logic [OUT_CELLS-1:0] coreOut,
	output logic [OUT_CELLS-1:0] padOut
);

	////////////////////////////////////////////////////////////////////////////
	// Pin sampling.

	logic [SYNC_LEN-1:0]  syncLevel;
	logic [SYNC_LEN-1:0]  syncRise;
	logic [SYNC_LEN-1:0]  syncFall;
	bsc_pins_s            pins;
	logic [IN_CELLS-1:0]  padSampled;
	logic                 tckRise;
	logic                 tckFall;
	logic                 hold;

	bsc_sync #(
		.WIDTH(SYNC_LEN)
	) pinSync (
		.clock  (clock),
		.reset  (reset),
		.asyncIn({padIn, testClock, testModeSelect, testDataIn, testResetN}),
		.level  (syncLevel),
		.rise   (syncRise),
		.fall   (syncFall)
	);

	assign pins       = syncLevel[PIN_BITS-1:0];
	assign padSampled = syncLevel[SYNC_LEN-1:PIN_BITS];
	assign tckRise    = syncRise[POS_TCK];
	assign tckFall    = syncFall[POS_TCK];
	assign hold       = reset | ~pins.testResetN;

	////////////////////////////////////////////////////////////////////////////
	// Controller.

	bsc_state_e state;

	bsc_tap_fsm tapFsm (
		.clock(clock),
		.hold (hold),
		.step (tckRise),
		.tms  (pins.testModeSelect),
		.state(state)
	);

	////////////////////////////////////////////////////////////////////////////
	// Instruction register.

	logic [IR_LEN-1:0] irShift;
	logic [IR_LEN-1:0] ir;
	logic [IR_LEN-1:0] next_irShift;
	logic [IR_LEN-1:0] next_ir;
	logic              capIr;
	logic              shIr;
	logic              updIr;
	bsc_path_e         path;

	assign capIr = tckRise && state == ST_CAP_IR;
	assign shIr  = tckRise && state == ST_SH_IR;
	assign updIr = tckFall && state == ST_UPD_IR;
	assign next_irShift = capIr ? IR_CAPTURE
		: shIr ? {pins.testDataIn, irShift[IR_LEN-1:1]} : irShift;
	assign next_ir = (state == ST_RESET) ? INS_IDCODE
		: updIr ? irShift : ir;
	assign path = bsc_path(ir);

	always_ff @(posedge clock) begin
		if (hold) begin
			irShift <= IR_CAPTURE;
			ir      <= INS_IDCODE;
		end else begin
			irShift <= next_irShift;
			ir      <= next_ir;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Data registers.

	logic                 capDr;
	logic                 shDr;
	logic                 updDr;
	logic                 bypassBit;
	logic                 next_bypassBit;
	logic [ID_LEN-1:0]    idShift;
	logic [ID_LEN-1:0]    next_idShift;
	logic [BSR_LEN-1:0]   chain;
	logic [BSR_LEN-1:0]   next_chain;
	logic [OUT_CELLS-1:0] cellUpd;
	logic [OUT_CELLS-1:0] next_cellUpd;
	logic                 loadCells;

	assign capDr = tckRise && state == ST_CAP_DR;
	assign shDr  = tckRise && state == ST_SH_DR;
	assign updDr = tckFall && state == ST_UPD_DR;

	// Bypass captures zero and then adds one stage to the board chain.
	assign next_bypassBit = (capDr && path == PATH_BYPASS) ? 1'b0
		: (shDr && path == PATH_BYPASS) ? pins.testDataIn : bypassBit;

	// Bit 0 sits next to TDO and leaves first; TDI enters at bit 31.
	assign next_idShift = (capDr && path == PATH_ID) ? ID_CODE
		: (shDr && path == PATH_ID) ? {pins.testDataIn, idShift[ID_LEN-1:1]}
		: idShift;

	// Input cells sit next to TDO; output cells capture what the pins show.
	assign next_chain = (capDr && path == PATH_CHAIN) ? {padOut, padSampled}
		: (shDr && path == PATH_CHAIN) ? {pins.testDataIn, chain[BSR_LEN-1:1]}
		: chain;

	assign loadCells    = updDr && path == PATH_CHAIN;
	assign next_cellUpd = loadCells ? chain[BSR_LEN-1:IN_CELLS] : cellUpd;

	always_ff @(posedge clock) begin
		if (hold) begin
			bypassBit <= 1'b0;
			idShift   <= ID_CODE;
			chain     <= '0;
		end else begin
			bypassBit <= next_bypassBit;
			idShift   <= next_idShift;
			chain     <= next_chain;
		end
	end

	// Update latches keep their value through a test reset so a preload survives.
	always_ff @(posedge clock) begin
		if (reset) begin
			cellUpd <= CELL_RESET;
		end else begin
			cellUpd <= next_cellUpd;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin drive.

	logic                 drivePins;
	logic [OUT_CELLS-1:0] next_padOut;

	assign drivePins   = ir == INS_EXTEST || ir == INS_CLAMP;
	assign next_padOut = drivePins ? cellUpd : coreOut;

	always_ff @(posedge clock) begin
		if (reset) begin
			padOut <= '0;
		end else begin
			padOut <= next_padOut;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial output.

	logic serialBit;
	logic next_tdo;
	logic next_tdoEn;

	assign serialBit = (path == PATH_ID) ? idShift[0]
		: (path == PATH_CHAIN) ? chain[0] : bypassBit;
	assign next_tdo = !tckFall ? testDataOut
		: (state == ST_SH_IR) ? irShift[0]
		: (state == ST_SH_DR) ? serialBit : testDataOut;
	assign next_tdoEn = tckFall ? bsc_is_shift(state) : testDataOutEn;

	always_ff @(posedge clock) begin
		if (hold) begin
			testDataOut   <= 1'b0;
			testDataOutEn <= 1'b0;
		end else begin
			testDataOut   <= next_tdo;
			testDataOutEn <= next_tdoEn;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (hold);

	sequence seqCaptureId;
		capDr && path == PATH_ID;
	endsequence

	sequence seqShiftFallId;
		tckFall && state == ST_SH_DR && path == PATH_ID;
	endsequence

	bypass_stage_a: assert property (
		(shDr && path == PATH_BYPASS) |=> bypassBit == $past(pins.testDataIn))
		else $error("Bypass stage did not take the data-in bit.");

	pins_extest_a: assert property (
		(ir == INS_EXTEST && !reset) |=> padOut == $past(cellUpd))
		else $error("External test did not drive the pins from the cells.");

	sample_normal_a: assert property (
		(ir == INS_SAMPLE) |=> padOut == $past(coreOut))
		else $error("Sample disturbed the normal pin values.");

	sample_capture_a: assert property (
		(capDr && ir == INS_SAMPLE) |=> chain[IN_CELLS-1:0] == $past(padSampled))
		else $error("Sample did not capture the input pins.");

	preload_cells_a: assert property (
		(updDr && ir == INS_SAMPLE) |=> cellUpd == $past(chain[BSR_LEN-1:IN_CELLS]))
		else $error("Preload did not reach the update latches.");

	clamp_bypass_a: assert property (
		(ir == INS_CLAMP) |-> path == PATH_BYPASS ##1 padOut == $past(cellUpd))
		else $error("Clamp did not select bypass while driving the pins.");

	idcode_load_a: assert property (
		seqCaptureId |=> idShift == ID_CODE)
		else $error("Identification register did not load its code.");

	id_order_a: assert property (
		seqShiftFallId |=> testDataOut == $past(idShift[0]) && testDataOutEn)
		else $error("Identification bit 0 did not leave first on TDO.");

	id_width_a: assert property (
		seqCaptureId |=> idShift[31:28] == ID_VERSION && idShift[27:12] == ID_PART
			&& idShift[11:1] == ID_MAKER && idShift[0] == 1'b1)
		else $error("Identification register fields do not form the 32-bit code.");

	trst_force_a: assert property (@(posedge clock) disable iff (reset)
		!pins.testResetN |=> state == ST_RESET && ir == INS_IDCODE)
		else $error("Test reset did not force test-logic-reset.");

	reset_instr_a: assert property (
		(state == ST_RESET) |=> ir == INS_IDCODE)
		else $error("Test-logic-reset did not load the identification instruction.");

	tdo_release_a: assert property (
		(tckFall && !bsc_is_shift(state)) |=> !testDataOutEn)
		else $error("TDO driven outside the shift states.");

	tdo_edge_a: assert property (
		(!tckFall && !hold) |=> testDataOut == $past(testDataOut))
		else $error("TDO changed away from a falling test clock edge.");

	tdo_enable_a: assert property (
		(tckFall && bsc_is_shift(state)) |=> testDataOutEn)
		else $error("TDO not driven in a shift state.");

	bypass_capture_a: assert property (
		(capDr && path == PATH_BYPASS) |=> !bypassBit)
		else $error("Bypass stage did not capture zero.");

	extest_update_a: assert property (
		(updDr && ir == INS_EXTEST) |=> cellUpd == $past(chain[BSR_LEN-1:IN_CELLS]))
		else $error("External test update did not load the output cells.");

	chain_shift_a: assert property (
		(shDr && path == PATH_CHAIN) |=> chain[BSR_LEN-1] == $past(pins.testDataIn)
			&& chain[BSR_LEN-2:0] == $past(chain[BSR_LEN-1:1]))
		else $error("Scan chain did not shift towards data out.");

	id_shift_a: assert property (
		(shDr && path == PATH_ID) |=> idShift[ID_LEN-1] == $past(pins.testDataIn)
			&& idShift[ID_LEN-2:0] == $past(idShift[ID_LEN-1:1]))
		else $error("Identification register did not shift towards data out.");

	ir_capture_a: assert property (
		capIr |=> irShift == IR_CAPTURE)
		else $error("Capture-IR did not load the fixed capture pattern.");

	ir_update_a: assert property (
		updIr |=> ir == $past(irShift))
		else $error("Update-IR did not load the shifted instruction.");

endmodule : bsc_tap_top

// file: bench/bsc_tester_model.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose: Board tester model that drives the test pins and reads data out.
// Assumes: One test clock period is eight system clocks (200 ns).
// Notes:   The test clock stands low between calls; data out is pulled up.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module bsc_tester_model
	import bsc_pkg::*;
(
	input  logic      clock,
	output bsc_pins_s pins,
	input  logic      testDataOut,
	input  logic      testDataOutEn
);
	logic tdoWire;

	// A released data out line floats to the pull-up level.
	assign tdoWire = testDataOutEn ? testDataOut : 1'b1;

	initial begin
		pins = '{testClock: 1'b0, testModeSelect: 1'b1, testDataIn: 1'b0, testResetN: 1'b0};
	end

	task automatic halfWait();
		repeat (4) @(negedge clock);
	endtask : halfWait

	// Mode and data are set while the clock is low; data out is taken before the fall.
	task automatic tick(input logic tms, input logic tdi, output logic tdo, output logic en);
		pins.testModeSelect = tms;
		pins.testDataIn     = tdi;
		halfWait();
		pins.testClock = 1'b1;
		halfWait();
		tdo = tdoWire;
		en  = testDataOutEn;
		pins.testClock = 1'b0;
	endtask : tick

	task automatic setReset(input logic level);
		pins.testResetN = level;
		halfWait();
		halfWait();
	endtask : setReset

endmodule : bsc_tester_model

// file: bench/tb_top.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench for the boundary-scan test access port.
// Assumes: Tester model drives the test pins at eight clocks per test clock.
// Notes:   Scenarios shift through the path of a loaded instruction, or of the one that test-logic-reset leaves.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin nMismatch++; \
	$display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module tb_top
	import bsc_pkg::*;
;
	logic                 clock;
	logic                 reset;
	bsc_pins_s            pins;
	logic                 testDataOut;
	logic                 testDataOutEn;
	logic [IN_CELLS-1:0]  padIn;
	logic [OUT_CELLS-1:0] coreOut;
	logic [OUT_CELLS-1:0] padOut;
	int                   nMismatch;
	int                   compares;
	int                   cycles;

	bsc_tap_top dut (.clock(clock), .reset(reset), .testClock(pins.testClock),
		.testModeSelect(pins.testModeSelect), .testDataIn(pins.testDataIn),
		.testResetN(pins.testResetN), .testDataOut(testDataOut),
		.testDataOutEn(testDataOutEn), .padIn(padIn), .coreOut(coreOut), .padOut(padOut));

	bsc_tester_model tester (.clock(clock), .pins(pins), .testDataOut(testDataOut),
		.testDataOutEn(testDataOutEn));

	always #12.5 clock = ~clock;

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			nMismatch++;
			finishTest();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic finishTest();
		$display("compares %0d mismatches %0d", compares, nMismatch);
		if (nMismatch == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finishTest

	task automatic step(input logic tms);
		logic tdo;
		logic en;
		tester.tick(tms, 1'b0, tdo, en);
	endtask : step

	// Shifts n bits from the shift state, leaves through update to idle.
	task automatic shiftBits(input int n, input logic [63:0] din, output logic [63:0] dout);
		logic tdo;
		logic en;
		logic enAll;
		enAll = 1'b1;
		dout  = '0;
		for (int i = 0; i < n; i++) begin
			tester.tick(i == n - 1, din[i], tdo, en);
			dout[i] = tdo;
			enAll   = enAll & en;
		end
		tester.tick(1'b1, 1'b0, tdo, en);
		`CHECK(enAll, 1'b1)
		`CHECK(en, 1'b0)
		step(1'b0);
	endtask : shiftBits

	task automatic goShift(input logic toIr);
		logic tdo;
		logic en;
		step(1'b1);
		if (toIr) begin
			step(1'b1);
		end
		step(1'b0);
		tester.tick(1'b0, 1'b0, tdo, en);
		`CHECK(en, 1'b0)
	endtask : goShift

	task automatic loadIr(input logic [IR_LEN-1:0] op);
		logic [63:0] d;
		goShift(1'b1);
		shiftBits(IR_LEN, {60'h0, op}, d);
		`CHECK(d[IR_LEN-1:0], IR_CAPTURE)
	endtask : loadIr

	task automatic readDr(input int n, input logic [63:0] din, output logic [63:0] dout);
		goShift(1'b0);
		shiftBits(n, din, dout);
	endtask : readDr

	////////////////////////////////////////////////////////////////////////////////
	task automatic tIdAfterReset();
		logic [63:0] d;
		step(1'b0);
		readDr(40, 64'h0000_0000_0000_00C5, d);
		`CHECK(d[31:0], ID_CODE)
		`CHECK({d[31:28], d[27:12], d[11:1]}, {ID_VERSION, ID_PART, ID_MAKER})
		`CHECK(d[0], 1'b1)
		`CHECK(d[39:32], 8'hC5)
	endtask : tIdAfterReset

	task automatic tBypass();
		logic [63:0] d;
		logic [IR_LEN-1:0] ops [2];
		ops = '{INS_BYPASS, 4'h7};
		foreach (ops[k]) begin
			loadIr(ops[k]);
			readDr(8, 64'h0000_0000_0000_00B6, d);
			`CHECK(d[7:0], 8'h6C)
		end
	endtask : tBypass

	task automatic tSamplePreload();
		logic [63:0] d;
		padIn   = 4'hA;
		coreOut = 4'h5;
		loadIr(INS_SAMPLE);
		readDr(8, 64'h0000_0000_0000_003C, d);
		`CHECK(d[7:0], 8'h5A)
		`CHECK(padOut, 4'h5)
	endtask : tSamplePreload

	task automatic tExtest();
		logic [63:0] d;
		loadIr(INS_EXTEST);
		`CHECK(padOut, 4'h3)
		readDr(8, 64'h0000_0000_0000_0090, d);
		`CHECK(d[7:0], 8'h3A)
		`CHECK(padOut, 4'h9)
	endtask : tExtest

	task automatic tClamp();
		logic [63:0] d;
		loadIr(INS_CLAMP);
		coreOut = 4'hE;
		readDr(8, 64'h0000_0000_0000_005B, d);
		`CHECK(d[7:0], 8'hB6)
		`CHECK(padOut, 4'h9)
	endtask : tClamp

	task automatic tAsyncReset();
		logic [63:0] d;
		goShift(1'b0);
		step(1'b0);
		tester.setReset(1'b0);
		`CHECK(testDataOutEn, 1'b0)
		tester.setReset(1'b1);
		step(1'b0);
		readDr(32, 64'h0, d);
		`CHECK(d[31:0], ID_CODE)
		`CHECK(padOut, 4'hE)
	endtask : tAsyncReset

	task automatic tModeOnesReset();
		logic [63:0] d;
		loadIr(INS_BYPASS);
		goShift(1'b1);
		repeat (5) step(1'b1);
		step(1'b0);
		readDr(32, 64'h0, d);
		`CHECK(d[31:0], ID_CODE)
	endtask : tModeOnesReset

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clock     = 1'b0;
		reset     = 1'b1;
		padIn     = 4'h0;
		coreOut   = 4'h0;
		nMismatch = 0;
		compares  = 0;
		cycles    = 0;
		repeat (2) @(negedge clock);
		reset = 1'b0;
		repeat (6) @(negedge clock);
		tester.setReset(1'b1);
		tIdAfterReset();
		tBypass();
		tSamplePreload();
		tExtest();
		tClamp();
		tAsyncReset();
		tModeOnesReset();
		finishTest();
	end

endmodule : tb_top
